// File: bsw_defines.vh
// register offsets, field positions and constants of the bit stream unit
`ifndef BSW_DEFINES_VH
`define BSW_DEFINES_VH
`define BSW_OFS_MODE 8'h00
`define BSW_OFS_SEED 8'h04
`define BSW_OFS_STATE 8'h08
`define BSW_OFS_POLY 8'h0c
`define BSW_OFS_DATA 8'h10
`define BSW_OFS_LINK 8'h14
`define BSW_MODE_SHORT_EN 0
`define BSW_MODE_LONG_EN 1
`define BSW_MODE_CP_LO 2
`define BSW_MODE_CP_HI 3
`define BSW_MODE_BIT_ORDER 4
`define BSW_MODE_READOUT 5
`define BSW_MODE_BUSY 6
`define BSW_SEED_LONG_RESET 7
`define BSW_CP_RX 2'h1
`define BSW_CP_TX 2'h3
`define BSW_MODE_RESET 8'h00
`define BSW_SEED_RESET 7'h00
`define BSW_STATE_RESET 32'h00000000
`define BSW_POLY_RESET 32'h00000000
`define BSW_LONG_ONES9 9'h1ff
`define BSW_LONG_ONES8 8'hff
`define BSW_BITS_PER_BYTE 4'h8
`define BSW_CLK_MHZ 250
`define BSW_BIT_TIME_NS 4
`define BSW_BIT_CYCLES ((`BSW_BIT_TIME_NS * `BSW_CLK_MHZ + 999) / 1000)
`endif

// File: bsw_link_model.sv
// link layer engine model: per-packet loads and a paced bit feed
module bsw_link_model (
  // clock
  input wire logic hclk,
  // packet set-up
  output logic link_seed_load,
  output logic [7:0] whiten_init_var,
  output logic link_state_load,
  output logic [31:0] crc_init_var,
  output logic [2:0] crc_byte_count_var,
  output logic link_tx,
  // bit feed
  output logic link_bit_valid,
  output logic link_bit_in,
  output logic link_crc_phase
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet lines before the first packet
  initial begin
    {link_seed_load, link_state_load, link_bit_valid} = 3'h0;
    {link_crc_phase, link_tx, link_bit_in} = 3'h0;
    whiten_init_var = 8'h00;
    crc_init_var = 32'h0;
    crc_byte_count_var = 3'h1;
  end

  // seed and crc state are reloaded before every packet
  task automatic load(input [7:0] w, input [31:0] d, input [2:0] n,
    input t);
    whiten_init_var <= w;
    crc_init_var <= d;
    crc_byte_count_var <= n;
    link_tx <= t;
    link_crc_phase <= 1'b0;
    link_seed_load <= 1'b1;
    link_state_load <= 1'b1;
    @(posedge hclk);
    link_seed_load <= 1'b0;
    link_state_load <= 1'b0;
    @(posedge hclk);
  endtask

  // one bit; the idle line toggles so a stale bit never looks valid
  task automatic feed(input b, input c, input int gap);
    link_bit_in <= b;
    link_crc_phase <= c;
    link_bit_valid <= 1'b1;
    @(posedge hclk);
    link_bit_valid <= 1'b0;
    link_bit_in <= ~b;
    repeat (gap - 1) begin
      @(posedge hclk);
      link_bit_in <= ~link_bit_in;
    end
    @(posedge hclk);
  endtask
endmodule

// File: bsw_stream_unit.v
// bit stream unit: crc, whiteners, link feed and co-processor over ahb-lite
// Functional notes
// [R1] crc insert and check, order 8-32
// [R2] short whitener x^7+x^4+1, output equals feedback
// [R3] per-whitener enable, combined bit xored on data
// [R4] seed write loads reversed stages, stage0 one
// [R5] long whitener 9-bit sequence, reversed output byte
// [R6] long reset sets both registers all ones
// [R7] output byte reloaded after each byte
// [R8] engine seeds whitener, long reset on bit7
// [R9] 32-bit state and polynomial, taps where set
// [R10] controller loads polynomial once, state per packet
// [R11] state shifts out serially as crc field
// [R12] crc bytes whitened and de-whitened too
// [R13] reduced order needs zero low bits
// [R14] crc length whole bytes, 1 to 4
// [R15] ccitt polynomial bytes programmed by software
// [R16] mode 01 receive, 11 transmit
// [R17] data write starts byte, busy raised
// [R18] bit order lsb first at 0
// [R19] result whitened or unchanged
// [R20] readout returns one crc byte per write
// [R21] no co-processor while engine runs
// [R22] busy lasts eight clocks per byte
//
// Chosen here: the AHB-Lite slave port and the address map.
`include "bsw_defines.vh"
module bsw_stream_unit (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // link layer engine bit stream
  input wire link_seed_load,
  input wire [7:0] whiten_init_var,
  input wire link_state_load,
  input wire [31:0] crc_init_var,
  input wire [2:0] crc_byte_count_var,
  input wire link_tx,
  input wire link_bit_valid,
  input wire link_bit_in,
  input wire link_crc_phase,
  output reg link_bit_out_ff,
  output reg link_bit_valid_ff,
  output reg link_crc_ok_ff,
  output reg link_crc_done_ff
);
  // co-processor states
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg [7:0] mode_ff;
  reg [6:0] seed_ff;
  reg [31:0] crc_state_regs_ff;
  reg [31:0] crc_poly_regs_ff;
  reg [7:0] coproc_byte_ff;
  reg state_ff;
  reg [3:0] bit_cnt_ff;
  reg [7:0] work_ff;
  reg [5:0] crc_bits_ff;
  reg crc_err_ff;
  reg wr_pend_ff;
  reg [7:0] wr_addr_ff;
  reg [7:0] nxt_mode;
  wire [31:0] nxt_crc;
  wire crc_fb;
  reg nxt_data_bit;
  reg nxt_white_in;
  reg nxt_feed_crc;
  reg crc_step;
  reg white_step;
  wire [1:0] coproc_select;
  wire coproc_busy;
  wire coproc_bit_order;
  wire crc_readout_select;
  wire short_en;
  wire long_en;
  wire addr_phase;
  wire seed_wr;
  wire data_wr;
  wire long_reset;
  wire white_bit;
  wire [2:0] bit_idx;
  wire [2:0] sel_idx;
  wire cp_in_bit;
  wire crc_out_bit;
  wire [7:0] rd_mux;
  wire byte_done;
  wire seed_load;
  wire [6:0] seed_src;

  // mode fields
  assign short_en = mode_ff[`BSW_MODE_SHORT_EN];
  assign long_en = mode_ff[`BSW_MODE_LONG_EN];
  assign coproc_select = mode_ff[`BSW_MODE_CP_HI:`BSW_MODE_CP_LO];
  assign coproc_bit_order = mode_ff[`BSW_MODE_BIT_ORDER];
  assign crc_readout_select = mode_ff[`BSW_MODE_READOUT];
  assign coproc_busy = state_ff;

  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel & hready & htrans[1];

  // capture write address phase for the following data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_ff <= haddr;
      end
    end
  end

  // read data registered at address phase
  assign rd_mux = coproc_byte_ff;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase & ~hwrite) begin
      case (haddr)
        `BSW_OFS_MODE: hrdata <= {24'h000000, nxt_mode};
        `BSW_OFS_SEED: hrdata <= {25'h0000000, seed_ff};
        `BSW_OFS_STATE: hrdata <= crc_state_regs_ff;
        `BSW_OFS_POLY: hrdata <= crc_poly_regs_ff;
        `BSW_OFS_DATA: hrdata <= {24'h000000, rd_mux};
        `BSW_OFS_LINK: hrdata <= {30'h00000000, link_crc_ok_ff,
                                  crc_err_ff};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // busy shows live in the mode register
  always @* begin
    nxt_mode = mode_ff;
    nxt_mode[`BSW_MODE_BUSY] = coproc_busy; // R17
  end

  assign seed_wr = wr_pend_ff & (wr_addr_ff == `BSW_OFS_SEED);
  assign data_wr = wr_pend_ff & (wr_addr_ff == `BSW_OFS_DATA) &
                   coproc_select[0] & ~coproc_busy; // R17
  // long reset from software or engine seed with bit 7
  assign long_reset = (seed_wr & hwdata[`BSW_SEED_LONG_RESET]) |
    (link_seed_load & whiten_init_var[`BSW_SEED_LONG_RESET]); // R6 R8
  assign seed_load = seed_wr | link_seed_load; // R8
  assign seed_src = link_seed_load ? whiten_init_var[6:0] : hwdata[6:0];

  // software configuration registers; engine loads state per packet
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff <= `BSW_MODE_RESET;
      seed_ff <= `BSW_SEED_RESET;
      crc_poly_regs_ff <= `BSW_POLY_RESET;
    end else begin
      if (wr_pend_ff & (wr_addr_ff == `BSW_OFS_MODE)) begin
        mode_ff <= hwdata[7:0] & 8'h3f;
      end
      if (seed_load) begin
        seed_ff <= seed_src; // R8
      end
      if (wr_pend_ff & (wr_addr_ff == `BSW_OFS_POLY)) begin
        crc_poly_regs_ff <= hwdata; // R9 R15
      end
    end
  end

  // bit selection: lsb first when order is 0, msb first when 1
  assign bit_idx = bit_cnt_ff[2:0];
  assign sel_idx = coproc_bit_order ? (3'h7 - bit_idx) : bit_idx; // R18
  assign cp_in_bit = work_ff[sel_idx];
  // crc field leaves from the top of the state register
  assign crc_out_bit = crc_state_regs_ff[31]; // R11

  // datapath: whitening order and crc feed per mode
  always @* begin
    crc_step = 1'b0;
    white_step = 1'b0;
    nxt_white_in = 1'b0;
    nxt_feed_crc = 1'b0;
    nxt_data_bit = 1'b0;
    if (state_ff == ST_RUN) begin
      white_step = 1'b1;
      if (coproc_select == `BSW_CP_RX) begin
        // receive: de-whiten first, then crc
        nxt_data_bit = cp_in_bit ^ white_bit; // R16 R19
        nxt_feed_crc = nxt_data_bit;
        crc_step = 1'b1;
      end else if (crc_readout_select) begin
        // transmit readout: crc bit, then whitening
        nxt_data_bit = crc_out_bit ^ white_bit; // R20 R12
        crc_step = 1'b1;
        nxt_feed_crc = 1'b0;
      end else begin
        // transmit: crc on raw bit, whitening after
        nxt_feed_crc = cp_in_bit; // R16
        nxt_data_bit = cp_in_bit ^ white_bit; // R19
        crc_step = 1'b1;
      end
    end else if (link_bit_valid) begin
      white_step = 1'b1;
      crc_step = 1'b1;
      if (link_crc_phase & link_tx) begin
        nxt_data_bit = crc_out_bit ^ white_bit; // R11 R12
      end else begin
        nxt_white_in = link_bit_in ^ white_bit; // R3
        nxt_data_bit = nxt_white_in;
        nxt_feed_crc = link_tx ? link_bit_in : nxt_white_in; // R12
      end
    end
  end

  // shift register with taps where the polynomial bit is one
  assign crc_fb = nxt_feed_crc ^ crc_state_regs_ff[31]; // R9
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_crc
      if (g == 0) begin : g_first
        assign nxt_crc[g] = crc_fb & crc_poly_regs_ff[g];
      end else begin : g_rest
        assign nxt_crc[g] = crc_state_regs_ff[g - 1] ^
                            (crc_fb & crc_poly_regs_ff[g]); // R9
      end
    end
  endgenerate

  // crc state: software or engine load, then stepping
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_state_regs_ff <= `BSW_STATE_RESET;
    end else if (link_state_load) begin
      crc_state_regs_ff <= crc_init_var; // R10
    end else if (wr_pend_ff & (wr_addr_ff == `BSW_OFS_STATE)) begin
      crc_state_regs_ff <= hwdata; // R13
    end else if (crc_step) begin
      if (state_ff == ST_RUN & crc_readout_select &
          coproc_select == `BSW_CP_TX) begin
        crc_state_regs_ff <= {crc_state_regs_ff[30:0], 1'b0}; // R20
      end else if (link_crc_phase & link_tx & state_ff == ST_IDLE) begin
        crc_state_regs_ff <= {crc_state_regs_ff[30:0], 1'b0}; // R11
      end else begin
        crc_state_regs_ff <= nxt_crc; // R1
      end
    end
  end

  // co-processor byte engine, one bit per clock
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      work_ff <= 8'h00;
      coproc_byte_ff <= 8'h00;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (data_wr) begin
            state_ff <= ST_RUN; // R17
            bit_cnt_ff <= 4'h0;
            work_ff <= hwdata[7:0];
          end
        end
        ST_RUN: begin
          coproc_byte_ff[sel_idx] <= nxt_data_bit; // R18 R19
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
          if (bit_cnt_ff == `BSW_BITS_PER_BYTE - 4'h1) begin
            state_ff <= ST_IDLE; // R22
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // link bit counter keeps the long whitener byte aligned
  reg [2:0] link_cnt_ff;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_cnt_ff <= 3'h0;
    end else if (seed_load | long_reset) begin
      link_cnt_ff <= 3'h0;
    end else if (link_bit_valid & state_ff == ST_IDLE) begin
      link_cnt_ff <= link_cnt_ff + 3'h1;
    end
  end

  // crc field bit count and mismatch tracking on the link
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_bit_out_ff <= 1'b0;
      link_bit_valid_ff <= 1'b0;
      crc_bits_ff <= 6'h00;
      crc_err_ff <= 1'b0;
      link_crc_ok_ff <= 1'b0;
      link_crc_done_ff <= 1'b0;
    end else begin
      link_bit_valid_ff <= link_bit_valid & (state_ff == ST_IDLE);
      link_crc_done_ff <= 1'b0;
      if (link_bit_valid & state_ff == ST_IDLE) begin
        link_bit_out_ff <= nxt_data_bit;
      end
      if (link_state_load) begin
        crc_bits_ff <= 6'h00;
        crc_err_ff <= 1'b0;
      end else if (link_bit_valid & link_crc_phase &
                   state_ff == ST_IDLE) begin
        crc_bits_ff <= crc_bits_ff + 6'h01;
        if (crc_bits_ff + 6'h01 == {crc_byte_count_var, 3'h0}) begin
          link_crc_done_ff <= 1'b1; // R14
          // the last bit's own mismatch counts too
          link_crc_ok_ff <= ~crc_err_ff & ~(~link_tx &
            (crc_state_regs_ff[31] ^ nxt_white_in)); // R1
        end
        // receive: state msb differing from the de-whitened bit means mismatch
        if (~link_tx & (crc_state_regs_ff[31] ^ nxt_white_in)) begin
          crc_err_ff <= 1'b1; // R1
        end
      end
    end
  end

  wire [2:0] w_idx;
  assign w_idx = (state_ff == ST_RUN) ? bit_idx : link_cnt_ff;
  assign byte_done = (w_idx == 3'h7);

  bsw_whitener u_whitener (
    .hclk(hclk),
    .hresetn(hresetn),
    .short_en(short_en),
    .long_en(long_en),
    .seed_load(seed_load),
    .seed(seed_src),
    .long_reset(long_reset),
    .step(white_step),
    .byte_done(byte_done),
    .bit_idx(w_idx),
    .white_bit(white_bit)
  );
endmodule

// File: bsw_stream_unit_sva.sv
// port assertions of the bit stream unit
module bsw_chk (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // link
  input wire link_state_load,
  input wire link_bit_valid,
  input wire link_crc_phase,
  input wire link_bit_valid_ff,
  input wire link_crc_ok_ff,
  input wire link_crc_done_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // read address phase accepted at this edge
  wire rd_take = hsel & hready & htrans[1] & ~hwrite;

  chk_zero_wait: assert property (hreadyout)
    else $error("wait state inserted");
  chk_resp_okay: assert property (!hresp)
    else $error("error response seen");
  chk_bit_follows: assert property (link_bit_valid |=> link_bit_valid_ff)
    else $error("bit strobe lost");
  chk_bit_cause: assert property (link_bit_valid_ff |-> $past(link_bit_valid))
    else $error("bit strobe without input");
  chk_done_single: assert property (link_crc_done_ff |=> !link_crc_done_ff)
    else $error("crc done longer than a cycle");
  chk_done_cause: assert property (link_crc_done_ff |->
    $past(link_bit_valid && link_crc_phase))
    else $error("crc done not after a crc bit");
  chk_ok_hold: assert property ($changed(link_crc_ok_ff) |-> link_crc_done_ff
    || $past(link_crc_done_ff || link_state_load))
    else $error("crc verdict moved alone");
  chk_rdata_hold: assert property (!$past(rd_take) |-> $stable(hrdata))
    else $error("read data moved");
  chk_unmapped_zero: assert property (rd_take && haddr > 8'h14 |=>
    hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_mode_upper: assert property (rd_take && haddr == 8'h00 |=>
    hrdata[31:7] == 25'h0)
    else $error("mode upper bits set");

  // main scenarios reached
  cover property (link_crc_done_ff && link_crc_ok_ff);
  cover property (link_crc_done_ff && !link_crc_ok_ff);
  cover property (rd_take && haddr == 8'h10);
endmodule

bind bsw_stream_unit bsw_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .link_state_load,
  .link_bit_valid, .link_crc_phase, .link_bit_valid_ff, .link_crc_ok_ff,
  .link_crc_done_ff);

// File: bsw_stream_unit_tb.sv
// self-checking bench of the bit stream unit
`include "bsw_defines.vh"
module bsw_stream_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire hreadyout, hresp, link_seed_load, link_state_load, link_tx;
  wire link_bit_valid, link_bit_in, link_crc_phase;
  wire [7:0] whiten_init_var;
  wire [31:0] hrdata, crc_init_var;
  wire [2:0] crc_byte_count_var;
  wire link_bit_out_ff, link_bit_valid_ff, link_crc_ok_ff, link_crc_done_ff;
  int err_total = 0;
  int checks = 0;
  int done_n = 0;
  logic [7:0] rnd = 8'h4c;
  logic [7:0] got;
  logic [31:0] md, mp, rd;
  logic last_ok;
  logic [6:0] pw;
  logic outs[$];

  always #2 hclk = ~hclk;

  bsw_link_model link_layer_engine (.hclk, .link_seed_load, .whiten_init_var,
    .link_state_load, .crc_init_var, .crc_byte_count_var, .link_tx,
    .link_bit_valid, .link_bit_in, .link_crc_phase);
  bsw_stream_unit dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .link_seed_load, .whiten_init_var, .link_state_load, .crc_init_var,
    .crc_byte_count_var, .link_tx, .link_bit_valid, .link_bit_in,
    .link_crc_phase, .link_bit_out_ff, .link_bit_valid_ff,
    .link_crc_ok_ff, .link_crc_done_ff);

  // collect processed bits and crc verdicts
  always @(posedge hclk) begin
    if (link_bit_valid_ff === 1'b1)
      outs.push_back(link_bit_out_ff);
    if (link_crc_done_ff === 1'b1) begin
      done_n++;
      last_ok = link_crc_ok_ff;
    end
  end

  function automatic [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic cmp(input [31:0] g, input [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // single transfer; holds each phase until ready is seen high
  task automatic ahb(input w, input [7:0] a, input [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // reference crc step: feedback is input against state msb
  task automatic mbit(input b);
    logic fb;
    fb = b ^ md[31];
    md = {md[30:0], 1'b0} ^ (fb ? mp : 32'h0);
  endtask

  // reference short whitener: one byte of x^7+x^4+1, lsb first
  task automatic pn7(output [7:0] w);
    for (int i = 0; i < 8; i++) begin
      w[i] = pw[6] ^ pw[3];
      pw = {pw[5:0], w[i]};
    end
  endtask

  // one co-processor byte, busy polled under a bound
  task automatic cp(input [7:0] b);
    int n;
    ahb(1, `BSW_OFS_DATA, {24'h0, b});
    ahb(0, `BSW_OFS_MODE, 0);
    cmp(rd[`BSW_MODE_BUSY], 1);
    n = 0;
    while (rd[`BSW_MODE_BUSY] !== 1'b0 && n < 8) begin
      ahb(0, `BSW_OFS_MODE, 0);
      n++;
    end
    cmp(rd[`BSW_MODE_BUSY], 0);
    cmp(n, 4);
    ahb(0, `BSW_OFS_DATA, 0);
    got = rd[7:0];
  endtask

  // link packet: random data, then 16 crc bits; bad flips one crc bit
  task automatic pkt(input tx, input int bad, input int nb, input inv);
    logic e[$];
    logic [31:0] c;
    outs.delete();
    for (int i = 0; i < nb * 8; i++) begin
      rnd = lfsr(rnd);
      e.push_back(rnd[7] ^ inv);
      mbit(rnd[7]);
      link_layer_engine.feed(rnd[7], 1'b0, rnd[1:0] + 1);
    end
    c = md;
    for (int i = 0; i < 16; i++) begin
      e.push_back(c[31 - i]);
      link_layer_engine.feed(tx ? rnd[i % 8] : c[31 - i] ^ (i == bad), 1'b1, i % 2 + 1);
    end
    repeat (3) @(posedge hclk);
    if (tx && !inv)
      cmp(outs.size(), e.size());
    foreach (e[i])
      if ((tx && !inv) || i < nb * 8)
        cmp(outs[i], e[i]);
  endtask

  task automatic give_verdict;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #200000;
    err_total++;
    give_verdict;
  end

  initial begin
    logic [7:0] x[4];
    logic [7:0] y[4];
    logic [7:0] sd;
    logic [7:0] wb;
    int n;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values up to the first unmapped word
    for (int a = 0; a < 28; a += 4) begin
      ahb(0, a[7:0], 0);
      cmp(rd, 0);
    end
    ahb(1, 8'h18, 32'hffffffff);
    ahb(1, `BSW_OFS_MODE, 32'hc0);
    ahb(0, 8'h18, 0);
    cmp(rd, 0);
    ahb(0, `BSW_OFS_MODE, 0);
    cmp(rd, 0);
    ahb(1, `BSW_OFS_DATA, 32'h5a);
    ahb(0, `BSW_OFS_MODE, 0);
    cmp(rd[`BSW_MODE_BUSY], 0);
    // crc through both modes and both bit orders, then readout
    mp = 32'h10210000;
    md = 32'hffff0000;
    ahb(1, `BSW_OFS_POLY, mp);
    ahb(1, `BSW_OFS_STATE, md);
    ahb(0, `BSW_OFS_POLY, 0);
    cmp(rd, mp);
    for (int m = 0; m < 4; m++) begin
      ahb(1, `BSW_OFS_MODE,
        {27'h0, m[1], m[0] ? `BSW_CP_TX : `BSW_CP_RX, 2'h0});
      repeat (3) begin
        rnd = lfsr(rnd);
        cp(rnd);
        cmp(got, rnd);
        for (int i = 0; i < 8; i++)
          mbit(m[1] ? rnd[7 - i] : rnd[i]);
      end
    end
    ahb(1, `BSW_OFS_MODE, 32'h3c);
    for (int i = 0; i < 2; i++) begin
      cp(8'h00);
      cmp(got, md[31:24]);
      md = md << 8;
    end
    // long whitener: first byte sees the all-ones output byte
    ahb(1, `BSW_OFS_SEED, 32'h80);
    ahb(1, `BSW_OFS_MODE, 32'h0e);
    cp(8'h3c);
    cmp(got, 8'hc3);
    // short whitener: transmit, then receive undoes it
    n = 0;
    sd = 8'hc5;
    for (int p = 0; p < 2; p++) begin
      ahb(1, `BSW_OFS_SEED, {24'h0, sd});
      pw = {sd[0], sd[1], sd[2], sd[3], sd[4], sd[5], 1'b1};
      ahb(1, `BSW_OFS_MODE, p ? 32'h05 : 32'h0d);
      for (int i = 0; i < 4; i++) begin
        rnd = lfsr(rnd);
        if (p == 0)
          x[i] = rnd;
        cp(p ? y[i] : x[i]);
        y[i] = got;
        if (p == 1)
          cmp(got, x[i]);
        else begin
          n += (got != x[i]);
          pn7(wb);
          cmp(got, x[i] ^ wb);
        end
      end
    end
    cmp(n > 0, 1);
    // link traffic with the co-processor off
    ahb(1, `BSW_OFS_MODE, 0);
    md = 32'hffff0000;
    link_layer_engine.load(8'h00, md, 3'h2, 1'b1);
    pkt(1, 99, 3, 0);
    for (int k = 0; k < 2; k++) begin
      md = 32'hffff0000;
      link_layer_engine.load(8'h00, md, 3'h2, 1'b0);
      n = done_n;
      pkt(0, k ? 5 : 99, 3, 0);
      cmp(done_n, n + 1);
      cmp(last_ok, !k);
    end
    ahb(1, `BSW_OFS_MODE, 32'h02);
    link_layer_engine.load(8'h80, md, 3'h2, 1'b1);
    pkt(1, 99, 1, 1);
    give_verdict;
  end
endmodule

// File: bsw_whitener.v
// short and long whitener sequence generators, one bit per step
`include "bsw_defines.vh"
module bsw_whitener (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // control
  input wire short_en,
  input wire long_en,
  input wire seed_load,
  input wire [6:0] seed,
  input wire long_reset,
  input wire step,
  input wire byte_done,
  input wire [2:0] bit_idx,
  // combined whitening bit for this step
  output wire white_bit
);
  reg [6:0] short_ff;
  reg [8:0] long_ff;
  reg [7:0] obyte_ff;
  reg [6:0] nxt_short;
  reg [8:0] nxt_long;
  wire short_fb;
  wire long_bit;
  integer i;

  // feedback of x^7+x^4+1 is also the output bit
  assign short_fb = short_ff[6] ^ short_ff[3]; // R2
  // output byte is used bit reversed against the data byte
  assign long_bit = obyte_ff[3'h7 - bit_idx]; // R5
  // a disabled whitener contributes zero
  assign white_bit = (short_en & short_fb) ^ (long_en & long_bit); // R3

  // next sequence values
  always @* begin
    nxt_short = {short_ff[5:0], short_fb}; // R2
    nxt_long = {long_ff[7:0], long_ff[8] ^ long_ff[3]}; // R5
    for (i = 0; i < 6; i = i + 1) begin
      nxt_short[6 - i] = seed[i]; // R4
    end
    nxt_short[0] = 1'b1; // R4
  end

  // short whitener register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      short_ff <= `BSW_SEED_RESET;
    end else if (seed_load) begin
      short_ff <= nxt_short; // R4
    end else if (step) begin
      short_ff <= {short_ff[5:0], short_fb}; // R2
    end
  end

  // long whitener: sequence shifts per bit, output byte per byte
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      long_ff <= `BSW_LONG_ONES9;
      obyte_ff <= `BSW_LONG_ONES8;
    end else if (long_reset) begin
      long_ff <= `BSW_LONG_ONES9; // R6
      obyte_ff <= `BSW_LONG_ONES8; // R6
    end else if (step) begin
      long_ff <= nxt_long; // R7
      if (byte_done) begin
        obyte_ff <= nxt_long[7:0]; // R7
      end
    end
  end
endmodule
